// *** hw/can_phy_fault.sv ***
// CAN physical-layer fault monitor with APB registers and one interrupt.
// Assumes comparator inputs are asynchronous and the APB master runs on core_clk.
`timescale 1ns/1ps
// Overview of operation
// - Voltage comparator going to error level sets its status bit.
// - Any change of a voltage status bit sets its voltage flag.
// - Four voltage flags raise interrupt only with shared voltage enable.
// - Dominant transmit input past limit forces listen-only, bus recessive.
// - Dominant timeout sets timeout status and timeout flag.
// - Clear while dominant or status active keeps listen-only, flag sets again.
// - Timeout flag raises interrupt only with its own enable.
// - Over-current counts only while driving dominant.
// - Over-current comparator error edge sets its flag directly.
// - Two over-current flags raise interrupt only with shared enable.
module can_phy_fault import can_phy_fault_pkg::*; #(
	parameter int TIMEOUT_CYC = DOM_TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phy_tx_input,
	input wire logic [3:0] volt_cmp,
	input wire logic [1:0] oc_cmp,
	output logic phy_tx_out,
	output logic listen_only,
	output logic phy_irq_request
);
	// ============================================================
	// State
	typedef struct packed {
		logic [3:0] vf_status;
		logic dom_timeout_status;
		logic [6:0] flag;
		logic [2:0] en;
		tx_mode_t mode;
		logic [CNT_W-1:0] wcnt;
		logic [31:0] rdata;
		logic irq;
	} top_state_t;
	top_state_t st_q, st_d;
	logic [5:0] lvl, rise, fall;
	logic expired;
	logic wr, rd, hit;
	logic [6:0] clr;

	function automatic logic [6:0] pack_flags(input logic [3:0] v, input logic d,
		input logic [1:0] o);
		pack_flags = {o, d, v};
	endfunction

	// ============================================================
	// Comparator crossing
	cmp_sync #(.W(6)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({oc_cmp, volt_cmp}),
		.level_out(lvl),
		.rise_out(rise),
		.fall_out(fall)
	);

	// Dominant is low on the transmit input; counted in every mode
	dom_timer #(.LIMIT(TIMEOUT_CYC)) u_tmr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.active(~phy_tx_input),
		.expired(expired)
	);

	// ============================================================
	// APB decode
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign hit = (paddr == OFS_STATUS) | (paddr == OFS_FLAG) | (paddr == OFS_ENABLE);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign clr = (wr && paddr == OFS_FLAG && pstrb[0]) ? pwdata[6:0] : 7'h00;

	always_comb begin
		logic [6:0] set;
		logic drv_dom;
		set = 7'h00;
		drv_dom = 1'b0;
		st_d = st_q;
		drv_dom = (st_q.mode == TX_NORMAL) & ~phy_tx_input;
		// Status follows comparator error level
		st_d.vf_status = lvl[3:0];
		set[3:0] = rise[3:0] | fall[3:0];
		set[6:5] = rise[5:4] & {2{drv_dom}};
		st_d.dom_timeout_status = expired;
		case (st_q.mode)
			TX_NORMAL: begin
				if (expired) begin
					st_d.mode = TX_LISTEN;
					set[DT_BIT] = 1'b1;
				end
			end
			TX_LISTEN: begin
				if (clr[DT_BIT] && !st_q.flag[DT_BIT] == 1'b0) begin
					st_d.mode = TX_WAIT;
					st_d.wcnt = '0;
				end
			end
			TX_WAIT: begin
				// Failed retry must not lose a later timeout edge
				if (!phy_tx_input || expired) begin
					if (st_q.wcnt >= CNT_W'(RETRY_CYC)) begin
						st_d.mode = TX_LISTEN;
						set[DT_BIT] = 1'b1;
					end else begin
						st_d.wcnt = st_q.wcnt + 1'b1;
					end
				end else if (st_q.wcnt >= CNT_W'(REENABLE_CYC)) begin
					st_d.mode = TX_NORMAL;
				end else begin
					st_d.wcnt = st_q.wcnt + 1'b1;
				end
			end
			default: st_d.mode = TX_LISTEN;
		endcase
		// Set wins over a write-one clear
		st_d.flag = (st_q.flag & ~clr) | set;
		if (wr && paddr == OFS_ENABLE && pstrb[0]) begin
			st_d.en = pwdata[2:0];
		end
		st_d.irq = ((|st_d.flag[3:0]) & st_d.en[EN_VF_BIT])
			| (st_d.flag[DT_BIT] & st_d.en[EN_DT_BIT])
			| ((|st_d.flag[6:5]) & st_d.en[EN_OC_BIT]);
		if (rd) begin
			case (paddr)
				OFS_STATUS: st_d.rdata = {27'h0, st_q.dom_timeout_status, st_q.vf_status};
				OFS_FLAG: st_d.rdata = {25'h0, st_q.flag};
				OFS_ENABLE: st_d.rdata = {29'h0, st_q.en};
				default: st_d.rdata = ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.rdata;
	assign listen_only = (st_q.mode != TX_NORMAL);
	// Recessive while listen-only
	assign phy_tx_out = phy_tx_input | listen_only;
	assign phy_irq_request = st_q.irq;

	// ============================================================
	// Checks
	a_timeout_listen: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.mode == TX_NORMAL && expired) |=> listen_only && phy_tx_out)
		else $error("timeout did not force listen-only");
	a_timeout_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.mode == TX_NORMAL && expired) |=> st_q.flag[DT_BIT])
		else $error("timeout flag not set");
	a_status_level: assert property (@(posedge core_clk) disable iff (!rst_n)
		##1 st_q.vf_status == $past(lvl[3:0]))
		else $error("voltage status wrong");
	a_vf_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rise[0] || fall[0]) |=> st_q.flag[0])
		else $error("voltage flag not set");
	a_oc_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rise[4] && listen_only && !st_q.flag[5] && !clr[5]) |=> !st_q.flag[5])
		else $error("over-current flag set while not driving");
	a_irq_vf_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.flag[3:0] != 4'h0 && st_q.en[EN_VF_BIT]) |-> phy_irq_request)
		else $error("voltage irq missing");
	a_irq_none: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.en == 3'h0) |-> !phy_irq_request)
		else $error("irq with all masked");
	a_irq_dt: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.flag[DT_BIT] && st_q.en[EN_DT_BIT]) |-> phy_irq_request)
		else $error("timeout irq missing");
	a_irq_oc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.flag[6:5] != 2'h0 && st_q.en[EN_OC_BIT]) |-> phy_irq_request)
		else $error("over-current irq missing");
	a_retry_fail: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.mode == TX_WAIT && !phy_tx_input) [*8] |=> listen_only)
		else $error("left listen-only while dominant");
	a_reenable_time: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(st_q.mode == TX_WAIT) |-> listen_only [*8])
		else $error("re-enabled too early");
	c_timeout: cover property (@(posedge core_clk) disable iff (!rst_n)
		$rose(listen_only));
	c_reenable: cover property (@(posedge core_clk) disable iff (!rst_n)
		$fell(listen_only));
	c_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
		$rose(phy_irq_request));
endmodule

// *** hw/cmp_sync.sv ***
// Three-stage synchroniser with rising- and falling-edge pulses for comparator bits.
// Assumes one core clock and active-low asynchronous reset.
`timescale 1ns/1ps
module cmp_sync #(parameter int W = 6) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sync_state_t;
	sync_state_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	// Edges from stages two and three only; stage one is metastable
	assign level_out = st_q.s2;
	assign rise_out = st_q.s2 & ~st_q.s3;
	assign fall_out = ~st_q.s2 & st_q.s3;
endmodule

// *** hw/dom_timer.sv ***
// Saturating counter of consecutive active cycles.
// Assumes one core clock; limit given by the instantiating block.
`timescale 1ns/1ps
module dom_timer import can_phy_fault_pkg::*; #(parameter int LIMIT = DOM_TIMEOUT_CYC) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic active,
	output logic expired
);
	localparam logic [31:0] LIM = 32'(LIMIT);
	typedef struct packed {
		logic [31:0] cnt;
	} tmr_state_t;
	tmr_state_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		if (!active) begin
			st_d.cnt = ZERO_WORD;
		end else if (st_q.cnt < LIM) begin
			st_d.cnt = st_q.cnt + 32'h00000001;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign expired = (st_q.cnt >= LIM);
endmodule

// *** pkg/can_phy_fault_pkg.sv ***
// Constants for the CAN physical-layer fault monitor.
// Assumes a 200 MHz core clock and a 32-bit APB register bus.
package can_phy_fault_pkg;
	// ============================================================
	// Clock and timing
	localparam int CLK_MHZ = 200;
	localparam int DOM_TIMEOUT_US = 100;
	localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;
	localparam int REENABLE_MIN_NS = 1000;
	localparam int REENABLE_CYC = (REENABLE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int RETRY_NS = 4000;
	localparam int RETRY_CYC = (RETRY_NS * CLK_MHZ) / 1000;
	localparam int CNT_W = 16;
	// ============================================================
	// Register byte offsets
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_FLAG = 12'h004;
	localparam logic [11:0] OFS_ENABLE = 12'h008;
	// ============================================================
	// Field positions
	localparam int VF_LSB = 0;
	localparam int VF_N = 4;
	localparam int DT_BIT = 4;
	localparam int OC_LSB = 5;
	localparam int OC_N = 2;
	localparam int EN_VF_BIT = 0;
	localparam int EN_DT_BIT = 1;
	localparam int EN_OC_BIT = 2;
	localparam logic [6:0] FLAG_RST = 7'h00;
	localparam logic [2:0] EN_RST = 3'h0;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	typedef enum logic [1:0] {TX_NORMAL, TX_LISTEN, TX_WAIT} tx_mode_t;
endpackage

// *** verif/can_phy_fault_tb_top.sv ***
// Self-checking bench for the CAN physical-layer fault monitor.
// Assumes zero-wait APB slave and a short timeout parameter.
`timescale 1ns/1ps
module can_phy_fault_tb_top;
	import can_phy_fault_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hF, volt_cmp = 4'h0;
	logic [1:0] oc_cmp = 2'h0;
	logic pready, pslverr, last_err, phy_tx_input, phy_tx_out, listen_only, irq, dom = 1'b0;
	int err_count = 0, n_tests = 0;
	always #2.5 core_clk = ~core_clk;
	can_phy_fault #(.TIMEOUT_CYC(50)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phy_tx_input(phy_tx_input), .volt_cmp(volt_cmp), .oc_cmp(oc_cmp),
		.phy_tx_out(phy_tx_out), .listen_only(listen_only), .phy_irq_request(irq));
	tx_ctrl_model ctrl (.core_clk(core_clk), .rst_n(rst_n), .dom_cmd(dom),
		.phy_tx_input(phy_tx_input));
	// ============================================================
	// Tasks
	task automatic wc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
		end
	endtask
	task automatic b(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
	// ============================================================
	// Tests
	initial begin
		wc(10);
		rst_n <= 1'b1;
		wc(2);
		rc(OFS_STATUS, 32'h0);
		rc(OFS_FLAG, 32'h0);
		rc(OFS_ENABLE, 32'h0);
		rc(12'h00C, 32'h0);
		b(last_err, 1'b1);
		apb(1'b1, OFS_STATUS, 32'hFF);
		rc(OFS_STATUS, 32'h0);
		$display("done reset and map");
		volt_cmp <= 4'h5;
		wc(6);
		rc(OFS_STATUS, 32'h5);
		rc(OFS_FLAG, 32'h5);
		b(irq, 1'b0);
		apb(1'b1, OFS_ENABLE, 32'h1);
		wc(3);
		b(irq, 1'b1);
		apb(1'b1, OFS_FLAG, 32'h5);
		wc(3);
		rc(OFS_FLAG, 32'h0);
		b(irq, 1'b0);
		volt_cmp <= 4'h0;
		wc(6);
		rc(OFS_STATUS, 32'h0);
		rc(OFS_FLAG, 32'h5);
		apb(1'b1, OFS_FLAG, 32'h5);
		wc(20);
		rc(OFS_FLAG, 32'h0);
		$display("done voltage");
		apb(1'b1, OFS_ENABLE, 32'h4);
		oc_cmp <= 2'h3;
		wc(6);
		rc(OFS_FLAG, 32'h0);
		oc_cmp <= 2'h0;
		dom <= 1'b1;
		wc(4);
		oc_cmp <= 2'h1;
		wc(6);
		b(phy_tx_out, 1'b0);
		dom <= 1'b0;
		oc_cmp <= 2'h0;
		rc(OFS_FLAG, 32'h20);
		b(irq, 1'b1);
		apb(1'b1, OFS_ENABLE, 32'h3);
		wc(3);
		b(irq, 1'b0);
		apb(1'b1, OFS_FLAG, 32'h60);
		rc(OFS_FLAG, 32'h0);
		$display("done overcurrent");
		apb(1'b1, OFS_ENABLE, 32'h2);
		dom <= 1'b1;
		wc(60);
		b(listen_only, 1'b1);
		b(phy_tx_out, 1'b1);
		rc(OFS_STATUS, 32'h10);
		rc(OFS_FLAG, 32'h10);
		b(irq, 1'b1);
		// Clearing while still dominant must fail and re-flag
		apb(1'b1, OFS_FLAG, 32'h10);
		wc(20);
		b(listen_only, 1'b1);
		wc(820);
		rc(OFS_FLAG, 32'h10);
		dom <= 1'b0;
		wc(10);
		apb(1'b1, OFS_FLAG, 32'h10);
		wc(100);
		b(listen_only, 1'b1);
		wc(300);
		b(listen_only, 1'b0);
		rc(OFS_FLAG, 32'h0);
		b(irq, 1'b0);
		$display("done timeout");
		finish_test();
	end
endmodule

// *** verif/tx_ctrl_model.sv ***
// Protocol controller stand-in: drives the transmit input level.
// Assumes the bench commands dominant periods on the core clock.
`timescale 1ns/1ps
module tx_ctrl_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dom_cmd,
	output logic phy_tx_input
);
	// ============================================================
	// Transmit level, recessive (high) out of reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phy_tx_input <= 1'b1;
		end else begin
			phy_tx_input <= ~dom_cmd;
		end
	end
endmodule
